// [core/event_cross.sv]
// Purpose: move link events and levels into the system clock
// Assumes: link pulses last one link cycle
// Notes: toggles survive a link clock that stops after the frame
module event_cross
  import i2c_evt_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_rst_n, // System reset, active low
  input wire logic i_lk_clk, // Link clock
  input wire logic i_lk_rst_n, // Link reset, active low
  input wire evt_t i_lk_evt, // Pulses, link domain
  input wire lk_lvl_t i_lk_lvl, // Levels, link domain
  output evt_t o_evt, // Pulses, system domain
  output lk_lvl_t o_lvl // Levels, system domain
);
  typedef struct packed {
    evt_t s1;
    evt_t s2;
    evt_t s3;
    lk_lvl_t l1;
    lk_lvl_t l2;
  } x_state_t;

  evt_t tgl_ff;
  evt_t nxt_tgl;
  x_state_t st_ff;
  x_state_t nxt_st;

  // One toggle per event kind
  always_comb
  begin
    nxt_tgl = tgl_ff ^ i_lk_evt;
  end

  always_ff @(posedge i_lk_clk or negedge i_lk_rst_n)
  begin
    if (!i_lk_rst_n)
    begin
      tgl_ff <= '0;
    end
    else
    begin
      tgl_ff <= nxt_tgl;
    end
  end

  // Edge detect only on the second and third stages
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = tgl_ff;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.l1 = i_lk_lvl;
    nxt_st.l2 = st_ff.l1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_evt = st_ff.s2 ^ st_ff.s3;
  assign o_lvl = st_ff.l2;
endmodule

// [core/i2c_evt_pkg.sv]
// Purpose: shared constants and carriers for the raw event status block
// Assumes: 32-bit register bus, 7 live status bits
// Notes: offsets without a printed value are local picks
package i2c_evt_pkg;
  localparam int ADDR_W = 8;
  localparam int FLAG_W = 14;
  localparam int BYTE_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] CFG_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] MASKED_OFS = 8'h2C;
  localparam logic [ADDR_W-1:0] MASK_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] RAW_OFS = 8'h34;
  localparam logic [ADDR_W-1:0] CLR_ALL_OFS = 8'h40;
  localparam logic [ADDR_W-1:0] CLR_ACT_OFS = 8'h5C;
  localparam logic [ADDR_W-1:0] CLR_GC_OFS = 8'h68;
  // Status bit positions
  localparam int BIT_HOLD = 13;
  localparam int BIT_RESTART = 12;
  localparam int BIT_GC = 11;
  localparam int BIT_START = 10;
  localparam int BIT_STOP = 9;
  localparam int BIT_ACT = 8;
  localparam int BIT_RXD = 7;
  // Config bit positions
  localparam int CFG_EN = 0;
  localparam int CFG_STOP_ADDR = 7;
  localparam int CFG_STOP_MST = 10;
  localparam int CFG_DYN_TAR = 11;
  localparam int CFG_HOLD_EN = 12;
  localparam int CFG_RST_DET_EN = 13;
  // Reset values and writable bits
  localparam logic [FLAG_W-1:0] FLAG_RST = 14'h0000;
  localparam logic [FLAG_W-1:0] CFG_RST = 14'h0000;
  localparam logic [FLAG_W-1:0] CFG_WR = 14'h3C81;
  localparam logic [FLAG_W-1:0] MASK_RST = 14'h0880;
  localparam logic [FLAG_W-1:0] MASK_WR = 14'h1F80;
  localparam logic [FLAG_W-1:0] EVT_BITS = 14'h1F80;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Qualified bus events, one-cycle pulses
  typedef struct packed {
    logic rx_done;
    logic gc;
    logic stop;
    logic restart;
    logic start;
  } evt_t;
  // Slow levels from the bus side
  typedef struct packed {
    logic hold_empty;
    logic activity;
  } lk_lvl_t;
  // Qualifier options carried into the link domain
  typedef struct packed {
    logic stop_addr;
    logic stop_mst;
    logic restart_en;
  } lk_cfg_t;
  // Raw conditions from the bus engine, link clock
  typedef struct packed {
    logic start;
    logic restart;
    logic stop;
    logic gc_acked;
    logic slv_tx_nack;
    logic byte_rcvd;
    logic slave_mode;
    logic addressed;
    logic master_active;
    logic hs_or_startbyte;
    logic hold_empty;
    logic activity;
  } lk_bus_t;
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;
endpackage

// [core/i2c_raw_event_status.sv]
// Purpose: raw and masked event status of a two-wire controller
// Assumes: AXI4-Lite slave on i_clk, bus engine on i_lk_clk
// Notes: flags 12..7 are sticky, flag 13 follows a live level
// Contract
// - Raw status word is read-only and never gated by the mask.
// - Bit 13 shows master holding on empty FIFO, needs both options set.
// - Bit 12 sets on restart while addressed as slave, if detection enabled.
// - No restart flag in high-speed or start-byte transfers.
// - Bit 11 sets only on an acknowledged general call address.
// - General call flag holds until disable or a read of its own clear register.
// - Bytes after an acknowledged general call go to the receive path.
// - Bit 10 sets on any start or restart, master or slave.
// - Bit 9 sets on a stop, subject to the qualifying options.
// - Slave stop flags only when addressed if that option is set.
// - With that option, a general call never counts as addressed.
// - Master stop flags only while active if that option is set.
// - Bit 8 latches activity until disable, clear reads, or reset.
// - Bit 7 sets when slave transmitter sees a not-acknowledge.
// - Flags read one when active, zero when idle, reset to zero.
// - Masked status shows a raw flag only when its mask bit is one.
//
// Register access over AXI4-Lite was chosen for this implementation.
module i2c_raw_event_status
  import i2c_evt_pkg::*;
(
  input wire logic i_clk, // System clock, 125 MHz
  input wire logic i_rst_n, // System reset, active low
  input wire logic i_lk_clk, // Bus engine clock
  input wire logic i_lk_rst_n, // Bus engine reset, active low
  input wire lk_bus_t i_lk_bus, // Bus engine conditions
  output logic o_lk_store_byte, // Receive path push, link clock
  input wire logic i_awvalid, // Write address valid
  output logic o_awready, // Write address ready
  input wire logic [ADDR_W-1:0] i_awaddr, // Write address
  input wire logic i_wvalid, // Write data valid
  output logic o_wready, // Write data ready
  input wire logic [DATA_W-1:0] i_wdata, // Write data
  input wire logic [STRB_W-1:0] i_wstrb, // Write byte enables
  output logic o_bvalid, // Write response valid
  input wire logic i_bready, // Write response ready
  output logic [1:0] o_bresp, // Write response
  input wire logic i_arvalid, // Read address valid
  output logic o_arready, // Read address ready
  input wire logic [ADDR_W-1:0] i_araddr, // Read address
  output logic o_rvalid, // Read data valid
  input wire logic i_rready, // Read data ready
  output logic [DATA_W-1:0] o_rdata, // Read data
  output logic [1:0] o_rresp, // Read response
  output logic [FLAG_W-1:0] o_raw_event_status, // Raw flags
  output logic [FLAG_W-1:0] o_masked_event_status // Masked flags
);

  typedef struct packed {
    logic [FLAG_W-1:0] cfg;
    logic [FLAG_W-1:0] mask;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] masked;
    wr_state_t wr_st;
    logic aw_hold;
    logic w_hold;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;

  evt_t lk_evt;
  lk_lvl_t lk_lvl;
  evt_t sys_evt;
  lk_lvl_t sys_lvl;
  lk_cfg_t lk_cfg;

  // True for every mapped register address
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      CFG_OFS, MASKED_OFS, MASK_OFS, RAW_OFS:
        hit = 1'b1;
      CLR_ALL_OFS, CLR_ACT_OFS, CLR_GC_OFS:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Byte-lane merge for the writable registers
  function automatic logic [FLAG_W-1:0] wmerge(
    input logic [FLAG_W-1:0] old,
    input logic [DATA_W-1:0] d,
    input logic [STRB_W-1:0] s,
    input logic [FLAG_W-1:0] wr
  );
    logic [FLAG_W-1:0] r;
    r = old;
    if (s[0])
    begin
      r[BYTE_W-1:0] = d[BYTE_W-1:0];
    end
    if (s[1])
    begin
      r[FLAG_W-1:BYTE_W] = d[FLAG_W-1:BYTE_W];
    end
    return (r & wr) | (old & ~wr);
  endfunction

  // Zero-extend a status word; upper bits are reserved
  function automatic logic [DATA_W-1:0] widen(input logic [FLAG_W-1:0] v);
    return {{(DATA_W-FLAG_W){1'b0}}, v};
  endfunction

  // Options needed on the bus side
  assign lk_cfg.stop_addr = st_ff.cfg[CFG_STOP_ADDR];
  assign lk_cfg.stop_mst = st_ff.cfg[CFG_STOP_MST];
  assign lk_cfg.restart_en = st_ff.cfg[CFG_RST_DET_EN];

  link_qualify u_qualify (
    .i_lk_clk(i_lk_clk),
    .i_lk_rst_n(i_lk_rst_n),
    .i_bus(i_lk_bus),
    .i_cfg(lk_cfg),
    .o_evt(lk_evt),
    .o_lvl(lk_lvl),
    .o_store_byte(o_lk_store_byte)
  );

  event_cross u_cross (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_lk_clk(i_lk_clk),
    .i_lk_rst_n(i_lk_rst_n),
    .i_lk_evt(lk_evt),
    .i_lk_lvl(lk_lvl),
    .o_evt(sys_evt),
    .o_lvl(sys_lvl)
  );

  // Channel readiness; one write and one read in flight
  assign o_awready = (st_ff.wr_st == WR_COLLECT) & ~st_ff.aw_hold;
  assign o_wready = (st_ff.wr_st == WR_COLLECT) & ~st_ff.w_hold;
  assign o_arready = ~st_ff.rvalid;

  // Whole next-state computation
  always_comb
  begin
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic have_aw;
    logic have_w;
    logic [ADDR_W-1:0] wa;
    logic [DATA_W-1:0] wd;
    logic [STRB_W-1:0] ws;
    logic [FLAG_W-1:0] set_v;
    logic [FLAG_W-1:0] clr_v;
    logic [FLAG_W-1:0] sticky;
    logic hold_live;
    logic en;
    aw_take = 1'b0;
    w_take = 1'b0;
    ar_take = 1'b0;
    have_aw = 1'b0;
    have_w = 1'b0;
    wa = '0;
    wd = '0;
    ws = '0;
    set_v = '0;
    clr_v = '0;
    sticky = '0;
    hold_live = 1'b0;
    en = st_ff.cfg[CFG_EN];
    nxt_st = st_ff;

    aw_take = i_awvalid & o_awready;
    w_take = i_wvalid & o_wready;
    ar_take = i_arvalid & o_arready;

    // Write channels are caught in either order
    have_aw = st_ff.aw_hold | aw_take;
    have_w = st_ff.w_hold | w_take;
    wa = st_ff.aw_hold ? st_ff.awaddr : i_awaddr;
    wd = st_ff.w_hold ? st_ff.wdata : i_wdata;
    ws = st_ff.w_hold ? st_ff.wstrb : i_wstrb;
    if (aw_take)
    begin
      nxt_st.aw_hold = 1'b1;
      nxt_st.awaddr = i_awaddr;
    end
    if (w_take)
    begin
      nxt_st.w_hold = 1'b1;
      nxt_st.wdata = i_wdata;
      nxt_st.wstrb = i_wstrb;
    end

    case (st_ff.wr_st)
      WR_COLLECT:
      begin
        if (have_aw & have_w)
        begin
          nxt_st.aw_hold = 1'b0;
          nxt_st.w_hold = 1'b0;
          nxt_st.bresp = reg_hit(wa) ? RESP_OKAY : RESP_SLVERR;
          nxt_st.wr_st = WR_RESP;
          // Status, masked and clear words ignore writes
          if (wa == CFG_OFS)
          begin
            nxt_st.cfg = wmerge(st_ff.cfg, wd, ws, CFG_WR);
          end
          else if (wa == MASK_OFS)
          begin
            nxt_st.mask = wmerge(st_ff.mask, wd, ws, MASK_WR);
          end
        end
      end
      WR_RESP:
      begin
        if (i_bready)
        begin
          nxt_st.wr_st = WR_COLLECT;
        end
      end
      default:
      begin
        nxt_st.wr_st = WR_COLLECT;
        nxt_st.aw_hold = 1'b0;
        nxt_st.w_hold = 1'b0;
      end
    endcase

    // Read: data is the value before any clear takes effect, except the clear-all word, which reads zero
    if (st_ff.rvalid & i_rready)
    begin
      nxt_st.rvalid = 1'b0;
    end
    if (ar_take)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      nxt_st.rdata = '0;
      case (i_araddr)
        CFG_OFS:
          nxt_st.rdata = widen(st_ff.cfg);
        MASK_OFS:
          nxt_st.rdata = widen(st_ff.mask);
        RAW_OFS:
          nxt_st.rdata = widen(st_ff.flags);
        MASKED_OFS:
          nxt_st.rdata = widen(st_ff.masked);
        CLR_ALL_OFS:
        begin
          nxt_st.rdata = '0;
          clr_v = EVT_BITS;
          // General call has its own clear word, so the global clear spares it
          clr_v[BIT_GC] = 1'b0;
        end
        CLR_ACT_OFS:
        begin
          nxt_st.rdata = widen(FLAG_W'({st_ff.flags[BIT_ACT]}));
          clr_v[BIT_ACT] = 1'b1;
        end
        CLR_GC_OFS:
        begin
          nxt_st.rdata = widen(FLAG_W'({st_ff.flags[BIT_GC]}));
          clr_v[BIT_GC] = 1'b1;
        end
        default:
        begin
          nxt_st.rdata = '0;
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Events arriving from the bus side
    set_v[BIT_RESTART] = sys_evt.restart;
    set_v[BIT_GC] = sys_evt.gc;
    set_v[BIT_START] = sys_evt.start;
    set_v[BIT_STOP] = sys_evt.stop;
    set_v[BIT_ACT] = sys_lvl.activity;
    set_v[BIT_RXD] = sys_evt.rx_done;

    // Set beats a clear read in the same cycle
    sticky = ((st_ff.flags & ~clr_v) | set_v) & EVT_BITS;

    // Hold flag is live, not sticky
    hold_live = sys_lvl.hold_empty & st_ff.cfg[CFG_DYN_TAR]
                & st_ff.cfg[CFG_HOLD_EN];
    sticky[BIT_HOLD] = hold_live;

    // Disable clears every flag and keeps them clear
    if (en)
    begin
      nxt_st.flags = sticky;
    end
    else
    begin
      nxt_st.flags = FLAG_RST;
    end

    // Masked copy; a zero mask bit hides its flag
    nxt_st.masked = st_ff.flags & st_ff.mask;
  end

  // Single state register, async reset to constants only
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff.cfg <= CFG_RST;
      st_ff.mask <= MASK_RST;
      st_ff.flags <= FLAG_RST;
      st_ff.masked <= FLAG_RST;
      st_ff.wr_st <= WR_COLLECT;
      st_ff.aw_hold <= 1'b0;
      st_ff.w_hold <= 1'b0;
      st_ff.awaddr <= '0;
      st_ff.wdata <= '0;
      st_ff.wstrb <= '0;
      st_ff.bresp <= RESP_OKAY;
      st_ff.rvalid <= 1'b0;
      st_ff.rdata <= '0;
      st_ff.rresp <= RESP_OKAY;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Bus answers come straight from flops
  assign o_bvalid = (st_ff.wr_st == WR_RESP);
  assign o_bresp = st_ff.bresp;
  assign o_rvalid = st_ff.rvalid;
  assign o_rdata = st_ff.rdata;
  assign o_rresp = st_ff.rresp;
  assign o_raw_event_status = st_ff.flags;
  assign o_masked_event_status = st_ff.masked;
endmodule

// [core/link_qualify.sv]
// Purpose: link-side event qualification
// Assumes: bus engine inputs are registered on the link clock
// Notes: options arrive from the system clock and are resynced here
module link_qualify
  import i2c_evt_pkg::*;
(
  input wire logic i_lk_clk, // Link clock
  input wire logic i_lk_rst_n, // Link reset, active low
  input wire lk_bus_t i_bus, // Bus engine conditions
  input wire lk_cfg_t i_cfg, // Options, system domain
  output evt_t o_evt, // Qualified event pulses
  output lk_lvl_t o_lvl, // Registered levels
  output logic o_store_byte // Push byte into receive path
);
  typedef struct packed {
    lk_cfg_t c1;
    lk_cfg_t c2;
    evt_t evt;
    lk_lvl_t lvl;
    logic gc_sess;
    logic store;
  } q_state_t;

  q_state_t st_ff;
  q_state_t nxt_st;

  // Qualify restart and stop with the synced options
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.c1 = i_cfg;
    nxt_st.c2 = st_ff.c1;
    nxt_st.evt.start = i_bus.start | i_bus.restart;
    nxt_st.evt.restart = i_bus.restart & i_bus.slave_mode & i_bus.addressed
                         & st_ff.c2.restart_en;
    if (i_bus.hs_or_startbyte)
    begin
      nxt_st.evt.restart = 1'b0;
    end
    nxt_st.evt.gc = i_bus.gc_acked;
    // Addressed means own address match only, never a general call
    if (i_bus.slave_mode)
    begin
      nxt_st.evt.stop = i_bus.stop & (~st_ff.c2.stop_addr | i_bus.addressed);
    end
    else
    begin
      nxt_st.evt.stop = i_bus.stop & (~st_ff.c2.stop_mst | i_bus.master_active);
    end
    nxt_st.evt.rx_done = i_bus.slv_tx_nack;
    nxt_st.lvl.hold_empty = i_bus.hold_empty;
    nxt_st.lvl.activity = i_bus.activity;
    // General call session lasts until the next start or stop
    if (i_bus.gc_acked)
    begin
      nxt_st.gc_sess = 1'b1;
    end
    else if (i_bus.start | i_bus.restart | i_bus.stop)
    begin
      nxt_st.gc_sess = 1'b0;
    end
    nxt_st.store = i_bus.byte_rcvd & (i_bus.addressed | st_ff.gc_sess);
  end

  always_ff @(posedge i_lk_clk or negedge i_lk_rst_n)
  begin
    if (!i_lk_rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_evt = st_ff.evt;
  assign o_lvl = st_ff.lvl;
  assign o_store_byte = st_ff.store;
endmodule

// [testbench/bus_engine_model.sv]
// Purpose: bus engine stand-in driving link conditions
// Assumes: link clock runs from start-up until the first frame ends, then only inside a frame
// Notes: pulses last one link cycle, levels other than activity persist
module bus_engine_model
  import i2c_evt_pkg::*;
(
  output logic o_lk_clk, // Link clock, 32 ns in frames
  output lk_bus_t o_bus // Conditions toward the block
);
  timeunit 1ns;
  timeprecision 100ps;
  logic run;
  // Odd start offset keeps phase unrelated to the system clock
  initial
  begin
    run = 1'b1;
    o_bus = '0;
    o_lk_clk = 1'b0;
    #5;
    forever
    begin
      #16;
      o_lk_clk = run ? ~o_lk_clk : 1'b0;
    end
  end
  // Levels first so option flops settle, then one pulse cycle
  task automatic frame(input logic [11:0] v);
    run = 1'b1;
    @(posedge o_lk_clk);
    o_bus <= v & 12'h03F;
    repeat (3) @(posedge o_lk_clk);
    o_bus <= v;
    @(posedge o_lk_clk);
    o_bus <= v & 12'h03F;
    @(posedge o_lk_clk);
    o_bus <= v & 12'h03E; // Engine idles after the frame
    repeat (3) @(posedge o_lk_clk);
    run = 1'b0;
  endtask
endmodule

// [testbench/i2c_raw_event_status_test.sv]
// Purpose: register-level test of the raw event status block
// Assumes: bus engine model paces the link frames
// Notes: sticky flags are cleared after every table step
module i2c_raw_event_status_test
  import i2c_evt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, lk_rst_n, lk_clk, lk_store;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rd_v;
  logic [STRB_W-1:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [FLAG_W-1:0] raw, masked;
  lk_bus_t lk_bus;
  int mismatches, compares, stores;
  // Config, link conditions, expected raw word
  localparam logic [39:0] TBL [15] = '{
    {14'h0001, 12'h800, 14'h0400},
    {14'h2001, 12'h430, 14'h1400},
    {14'h2001, 12'h434, 14'h0400},
    {14'h0001, 12'h430, 14'h0400},
    {14'h0081, 12'h220, 14'h0000},
    {14'h0081, 12'h230, 14'h0200},
    {14'h0001, 12'h220, 14'h0200},
    {14'h0401, 12'h200, 14'h0000},
    {14'h0401, 12'h208, 14'h0200},
    {14'h0001, 12'h200, 14'h0200},
    {14'h0001, 12'h0A0, 14'h0080},
    {14'h0001, 12'h001, 14'h0100},
    {14'h1801, 12'h002, 14'h2000},
    {14'h1001, 12'h002, 14'h0000},
    {14'h0000, 12'h800, 14'h0000}
  };
  i2c_raw_event_status i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_lk_clk(lk_clk), .i_lk_rst_n(lk_rst_n),
    .i_lk_bus(lk_bus), .o_lk_store_byte(lk_store), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .o_raw_event_status(raw), .o_masked_event_status(masked)
  );
  bus_engine_model i_eng (.o_lk_clk(lk_clk), .o_bus(lk_bus));
  // System clock, 8 ns
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Receive-path pushes counted in the link domain
  always @(posedge lk_clk)
    stores <= stores + int'(lk_store);
  task automatic stop_test();
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ap;
    logic wp;
    ap = 1'b1;
    wp = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (ap || wp)
    begin
      @(posedge clk);
      ap = ap && !awready;
      wp = wp && !wready;
      if (!ap)
        awvalid <= 1'b0;
      if (!wp)
        wvalid <= 1'b0;
    end
    do
      @(posedge clk);
    while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  // Address held until taken, data taken at the valid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge clk);
    while (!arready);
    arvalid <= 1'b0;
    do
      @(posedge clk);
    while (!rvalid);
    d = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, rd_v);
    check(rd_v, e);
  endtask
  // Hang guard, far beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  initial
  begin
    rst_n = 1'b0;
    lk_rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    lk_rst_n <= 1'b1;
    rc(RAW_OFS, 32'h0);
    rc(MASKED_OFS, 32'h0);
    rc(MASK_OFS, 32'h880);
    wr(RAW_OFS, 32'hFFFFFFFF);
    check(32'(rsp), 32'(RESP_OKAY));
    rc(RAW_OFS, 32'h0);
    rc(8'h36, 32'h0);
    check(32'(rsp), 32'(RESP_SLVERR));
    // One bus event per step, then clear the sticky flags
    for (int i = 0; i < 15; i++)
    begin
      wr(CFG_OFS, {18'h0, TBL[i][39:26]});
      i_eng.frame(TBL[i][25:14]);
      rc(RAW_OFS, {18'h0, TBL[i][13:0]});
      rc(CLR_ALL_OFS, 32'h0);
    end
    wr(CFG_OFS, 32'h1);
    i_eng.frame(12'h001);
    rc(CLR_ACT_OFS, 32'h1);
    rc(RAW_OFS, 32'h0);
    // Acked call, following byte, then a stop that must not count
    wr(CFG_OFS, 32'h81);
    i_eng.frame(12'h120);
    rc(RAW_OFS, 32'h800);
    i_eng.frame(12'h060);
    check(32'(stores), 32'h1);
    i_eng.frame(12'h220);
    rc(CLR_ALL_OFS, 32'h0);
    rc(RAW_OFS, 32'h800);
    wr(MASK_OFS, 32'hFFFFFFFF);
    rc(MASK_OFS, 32'h1F80);
    rc(MASKED_OFS, 32'h800);
    check({18'h0, masked}, 32'h800);
    wr(MASK_OFS, 32'h0);
    rc(MASKED_OFS, 32'h0);
    rc(RAW_OFS, 32'h800);
    rc(CLR_GC_OFS, 32'h1);
    rc(RAW_OFS, 32'h0);
    i_eng.frame(12'h120);
    wr(CFG_OFS, 32'h0);
    rc(RAW_OFS, 32'h0);
    stop_test();
  end
endmodule

// [testbench/raw_status_chk.sv]
// Purpose: concurrent checks on the raw event status block
// Assumes: link pulses are sampled on the system clock
// Notes: age counters tie flags 12..9 and 7 to a recent bus event
module raw_status_chk
  import i2c_evt_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_rst_n, // System reset, active low
  input wire lk_bus_t i_lk_bus, // Bus engine conditions
  input wire logic i_awvalid, // Write address valid
  input wire logic o_awready, // Write address ready
  input wire logic i_wvalid, // Write data valid
  input wire logic o_wready, // Write data ready
  input wire logic i_arvalid, // Read address valid
  input wire logic o_arready, // Read address ready
  input wire logic [ADDR_W-1:0] i_araddr, // Read address
  input wire logic o_rvalid, // Read data valid
  input wire logic i_rready, // Read data ready
  input wire logic [DATA_W-1:0] o_rdata, // Read data
  input wire logic [1:0] o_rresp, // Read response
  input wire logic [FLAG_W-1:0] o_raw_event_status, // Raw flags
  input wire logic [FLAG_W-1:0] o_masked_event_status // Masked flags
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0][3:0] age_ff; // Since start, restart, stop, call, nack
  logic [3:0] hs_ff; // Since a bus handshake
  logic [ADDR_W-1:0] rd_addr_ff; // Read in flight
  logic [4:0] pulse;
  logic bus_hs;
  logic [FLAG_W-1:0] raw;
  // Link pulses last four system cycles, so plain sampling sees them
  assign pulse = {i_lk_bus.start | i_lk_bus.restart, i_lk_bus.restart, i_lk_bus.stop, i_lk_bus.gc_acked,
    i_lk_bus.slv_tx_nack};
  // A clear read acts at the edge its address is taken, so that edge counts too
  assign bus_hs = (i_awvalid & o_awready) | (i_wvalid & o_wready) | (i_arvalid & o_arready)
    | (o_rvalid & i_rready);
  assign raw = o_raw_event_status;
  // Saturating ages, so stale events never excuse a flag
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      age_ff <= '1;
      hs_ff <= 4'hF;
      rd_addr_ff <= '0;
    end
    else
    begin
      for (int i = 0; i < 5; i++)
        age_ff[i] <= pulse[i] ? 4'h0 : age_ff[i] + 4'(age_ff[i] != 4'hF);
      hs_ff <= bus_hs ? 4'h0 : hs_ff + 4'(hs_ff != 4'hF);
      if (i_arvalid && o_arready)
        rd_addr_ff <= i_araddr;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_low_bits_zero: assert property (raw[6:0] == 7'h00)
    else $error("raw low bits set");
  a_mask_subset: assert property ((o_masked_event_status & ~$past(raw)) == 14'h0000)
    else $error("masked flag without raw flag");
  a_start_cause: assert property ($rose(raw[10]) |-> age_ff[4] != 4'hF)
    else $error("start flag without start");
  a_restart_cause: assert property ($rose(raw[12]) |-> age_ff[3] != 4'hF)
    else $error("restart flag without restart");
  a_stop_cause: assert property ($rose(raw[9]) |-> age_ff[2] != 4'hF)
    else $error("stop flag without stop");
  a_call_cause: assert property ($rose(raw[11]) |-> age_ff[1] != 4'hF)
    else $error("call flag without acked call");
  a_done_cause: assert property ($rose(raw[7]) |-> age_ff[0] != 4'hF)
    else $error("done flag without nack");
  a_activity_held: assert property ($fell(raw[8]) |-> hs_ff < 4'h5)
    else $error("activity flag dropped alone");
  a_call_held: assert property (raw[11] && !bus_hs && hs_ff > 4'h4 |=> raw[11])
    else $error("call flag dropped alone");
  a_raw_read_word: assert property ($rose(o_rvalid) && rd_addr_ff == RAW_OFS |->
    o_rdata == {18'h0, $past(raw)} && o_rresp == RESP_OKAY)
    else $error("raw word read wrong");
  c_restart: cover property ($rose(raw[12]));
  c_hold: cover property ($rose(raw[13]));
  c_call_clear: cover property ($fell(raw[11]));
endmodule

bind i2c_raw_event_status raw_status_chk u_chk (.i_clk, .i_rst_n, .i_lk_bus, .i_awvalid, .o_awready,
  .i_wvalid, .o_wready, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp,
  .o_raw_event_status, .o_masked_event_status);
